/* File: test_watchdog_timeout_response.sv */
`timescale 1ns/1ps
`include "wdtr_defs.vh"
module test_watchdog_timeout_response;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [1:0] trans = 2'h0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic tk = 1'b0;
    logic opt = 1'b0;
    logic dbg = 1'b0;
    logic go = 1'b0;
    logic rdy, stp, irq, rst, wake, lvl;
    logic [31:0] hr, rd;
    logic [23:0] rl, nv;
    int ni, nr, nw;
    int err_total = 0;
    int n_compared = 0;
    wdtr_top dut_u (.core_clk(clk), .rst_n(rst_n), .hsel(sel), .haddr(addr), .htrans(trans),
        .hwrite(wr), .hsize(3'h2), .hwdata(wd), .hready(rdy), .hreadyout(rdy), .hresp(),
        .hrdata(hr), .wdt_tick_pin(tk), .opt_response_pin(opt), .stop_mode(stp),
        .on_chip_debugger_mode(dbg), .wdt_irq_req_q(irq), .sys_rst_req_q(rst),
        .stop_recovery_req_q(wake), .irq_q(lvl));
    wdtr_far far_u (.clk(clk), .irq(irq), .rst(rst), .wake(wake), .go_stop(go), .stop(stp),
        .n_irq(ni), .n_rst(nr), .n_wake(nw));
    initial
    begin
        forever #20 clk = ~clk;
    end
    // ==========
    // Tasks
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1)
        begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
        sel <= 1'b1;
        trans <= 2'h2;
        wr <= w;
        addr <= {2'h0, idx, 2'h0};
        wait_rdy();
        sel <= 1'b0;
        trans <= 2'h0;
        wd <= {24'h0, d};
        wait_rdy();
        rd = hr;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask
    task automatic rdcnt(input logic [23:0] v, input string what);
        rdchk(`WDTR_IDX_UPPER, {24'h0, v[23:16]}, what);
        rdchk(`WDTR_IDX_MIDDLE, {24'h0, v[15:8]}, what);
        rdchk(`WDTR_IDX_LOW, {24'h0, v[7:0]}, what);
    endtask
    task automatic setrl(input logic [23:0] v);
        bus(1'b1, `WDTR_IDX_UPPER, v[23:16]);
        bus(1'b1, `WDTR_IDX_MIDDLE, v[15:8]);
        bus(1'b1, `WDTR_IDX_LOW, v[7:0]);
    endtask
    // The extra low cycles let request counts settle before they are read.
    task automatic ticks(input int k);
        repeat (k)
        begin
            tk <= 1'b1;
            repeat (2) @(posedge clk);
            tk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic chk_lvl(input logic exp, input string what);
        repeat (2) @(posedge clk);
        #1;
        check(what, {31'h0, lvl}, {31'h0, exp});
    endtask
    task automatic do_reset(input logic o);
        rst_n <= 1'b0;
        opt <= o;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [23:0] after(input logic [23:0] v, input int k);
        return (k <= v) ? v - k[23:0] : 24'h0fffff - (k[23:0] - v - 24'h1);
    endfunction
    // ==========
    // Main sequence
    initial
    begin
        void'($urandom(32'h4865));
        do_reset(1'b0);
        rdchk(`WDTR_IDX_UPPER, 32'h00, "upper");
        rdchk(`WDTR_IDX_MIDDLE, 32'h04, "middle");
        rdchk(`WDTR_IDX_LOW, 32'h00, "low");
        rdchk(12'h123, 32'h0, "unmapped");
        rl = 24'd3 + 24'($urandom % 6);
        nv = rl + 24'd1 + 24'($urandom % 4);
        setrl(rl);
        bus(1'b1, `WDTR_IDX_CTRL, 8'h01);
        rdcnt(rl, "load");
        bus(1'b1, `WDTR_IDX_LOW, nv[7:0]);
        ticks(1);
        rdcnt(after(rl, 1), "dec");
        bus(1'b1, `WDTR_IDX_CTRL, 8'h03);
        rdcnt(nv, "refresh");
        bus(1'b1, `WDTR_IDX_INT_MASK, 8'h01);
        ticks(nv - 1);
        check("early", ni, 0);
        ticks(1);
        check("irq", ni, 1);
        check("no reset", nr, 0);
        chk_lvl(1'b1, "irq line");
        rdchk(`WDTR_IDX_STAT, 32'h1, "flag");
        rdchk(`WDTR_IDX_STAT, 32'h0, "flag read");
        bus(1'b1, `WDTR_IDX_INT_MASK, 8'h00);
        chk_lvl(1'b0, "masked");
        bus(1'b1, `WDTR_IDX_INT_MASK, 8'h01);
        bus(1'b1, `WDTR_IDX_INT_STAT, 8'h01);
        chk_lvl(1'b0, "cleared");
        ticks(2);
        rdcnt(after(24'h0, 2), "wrap");
        dbg <= 1'b1;
        ticks(nv + 2);
        check("debug", ni, 1);
        dbg <= 1'b0;
        rdcnt(nv, "debug hold");
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        ticks(nv);
        check("wake", nw, 1);
        check("wake irq", ni, 2);
        check("awake", {31'h0, stp}, 32'h0);
        rdchk(`WDTR_IDX_STAT, 32'h3, "stop flags");
        rdchk(`WDTR_IDX_INT_STAT, 32'h3, "stop event");
        do_reset(1'b1);
        setrl(rl);
        bus(1'b1, `WDTR_IDX_CTRL, 8'h01);
        ticks(rl);
        check("reset req", nr, 1);
        check("one response", ni, 2);
        bus(1'b0, `WDTR_IDX_STAT, 8'h00);
        check("select", rd & 32'h4, 32'h4);
        give_verdict();
    end
endmodule

/* File: wdtr_chk_assertions.sv */
`timescale 1ns/1ps
// ==========
// Checker
module wdtr_chk
(
    // Clock and reset
    input logic core_clk,
    input logic rst_n,
    // Bus
    input logic hreadyout,
    input logic hresp,
    // Pins
    input logic wdt_tick_pin,
    input logic stop_mode,
    input logic on_chip_debugger_mode,
    // Requests
    input logic wdt_irq_req_q,
    input logic sys_rst_req_q,
    input logic stop_recovery_req_q
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire any_q = wdt_irq_req_q | sys_rst_req_q;
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    AST_ONE_RESPONSE: assert property (!(wdt_irq_req_q && sys_rst_req_q))
        else $error("two responses at once");
    AST_IRQ_PULSE: assert property (wdt_irq_req_q |=> !wdt_irq_req_q)
        else $error("interrupt request too long");
    AST_RST_PULSE: assert property (sys_rst_req_q |=> !sys_rst_req_q)
        else $error("reset request too long");
    AST_RST_NO_WAKE: assert property (sys_rst_req_q |-> !stop_recovery_req_q)
        else $error("wake with reset response");
    AST_WAKE_IRQ: assert property (stop_recovery_req_q |-> wdt_irq_req_q)
        else $error("wake without interrupt");
    AST_WAKE_STOP: assert property (stop_recovery_req_q |-> $past(stop_mode))
        else $error("wake outside stop");
    AST_DEBUG_QUIET: assert property (on_chip_debugger_mode [*3] |-> !any_q)
        else $error("time-out in debug");
    // A time-out can only follow a tick, seen three edges late.
    AST_AFTER_TICK: assert property (any_q |-> $past(wdt_tick_pin, 3))
        else $error("time-out without tick");
    CV_IRQ: cover property (wdt_irq_req_q);
    CV_RST: cover property (sys_rst_req_q);
    CV_WAKE: cover property (stop_recovery_req_q);
endmodule

bind wdtr_top wdtr_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .hreadyout(hreadyout), .hresp(hresp),
    .wdt_tick_pin(wdt_tick_pin), .stop_mode(stop_mode),
    .on_chip_debugger_mode(on_chip_debugger_mode), .wdt_irq_req_q(wdt_irq_req_q),
    .sys_rst_req_q(sys_rst_req_q), .stop_recovery_req_q(stop_recovery_req_q));

/* File: wdtr_counter.v */
`timescale 1ns/1ps
`include "wdtr_defs.vh"

module wdtr_counter
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Control
    input wire load,
    input wire [23:0] load_val,
    input wire tick,
    // Status
    output reg [23:0] count_q,
    output wire expire
);

// ============================================================
// Down-counter

assign expire = tick && !load && (count_q == `WDTR_COUNT_ONE);

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        count_q <= {`WDTR_UPPER_RST, `WDTR_MIDDLE_RST, `WDTR_LOW_RST};
    end
    else if (load)
    begin
        count_q <= load_val;
    end
    else if (tick)
    begin
        if (count_q == `WDTR_COUNT_ZERO)
        begin
            count_q <= `WDTR_WRAP_VALUE;
        end
        else
        begin
            count_q <= count_q - `WDTR_COUNT_ONE;
        end
    end
end

endmodule

/* File: wdtr_defs.vh */
`ifndef WDTR_DEFS_VH
`define WDTR_DEFS_VH
// Overview of operation
// - A time-out is declared when the down-counter reaches zero.
// - Each time-out gives one response, interrupt or reset, chosen by an option bit caught at reset.
// - In interrupt response a time-out requests an interrupt and sets the timeout flag.
// - After an interrupt time-out the counter wraps to 0fffff and keeps counting, no reload.
// - Reading the reset status register clears the timeout flag.
// - An interrupt time-out in stop mode starts stop-mode recovery and requests an interrupt.
// - A time-out in stop mode sets both the timeout flag and the stop-recovery flag.
// - The upper reload byte holds bits 23 to 16 at index ff1 and resets to 00.
// - The middle reload byte holds bits 15 to 8 at index ff2 and resets to 04.
// - The low reload byte holds bits 7 to 0 at index ff3 and resets to 00.
// - Reload byte reads return the live count byte, writes update only the reload value.
// - On first enable the counter loads the reload value and counts down.
// - A refresh command reloads the counter from the reload value; counting resumes only if the same write keeps the enable bit set.
// - In debug mode the watchdog is refreshed continuously so it never times out.

// ============================================================
// Register indices; byte address is four times the index
`define WDTR_IDX_CTRL 12'hff0
`define WDTR_IDX_UPPER 12'hff1
`define WDTR_IDX_MIDDLE 12'hff2
`define WDTR_IDX_LOW 12'hff3
`define WDTR_IDX_STAT 12'hff4
`define WDTR_IDX_INT_STAT 12'hff5
`define WDTR_IDX_INT_MASK 12'hff6

// ============================================================
// Field positions
`define WDTR_CTRL_ENABLE 0
`define WDTR_CTRL_REFRESH 1
`define WDTR_STAT_TIMEOUT 0
`define WDTR_STAT_STOP 1
`define WDTR_STAT_RESP 2

// ============================================================
// Reset and special values
`define WDTR_UPPER_RST 8'h00
`define WDTR_MIDDLE_RST 8'h04
`define WDTR_LOW_RST 8'h00
`define WDTR_COUNT_ZERO 24'h000000
`define WDTR_COUNT_ONE 24'h000001
`define WDTR_WRAP_VALUE 24'h0fffff
// The option pin passes two flops after release, so the third edge is the
// first one at which the second flop holds the pin and not its reset value.
`define WDTR_OPT_CAPTURE 2'h3

`endif

/* File: wdtr_far.sv */
`timescale 1ns/1ps
// ==========
// Interrupt, reset and stop logic
module wdtr_far
(
    // Clock
    input logic clk,
    // Requests
    input logic irq,
    input logic rst,
    input logic wake,
    // Stop entry
    input logic go_stop,
    output logic stop = 1'b0,
    // Counts
    output int n_irq = 0,
    output int n_rst = 0,
    output int n_wake = 0
);
    // Counts survive device resets so results compare across them.
    always @(posedge clk)
    begin
        n_irq <= n_irq + irq;
        n_rst <= n_rst + rst;
        n_wake <= n_wake + wake;
        stop <= wake ? 1'b0 : (go_stop | stop);
    end
endmodule

/* File: wdtr_top.v */
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "wdtr_defs.vh"

module wdtr_top
(
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [15:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Watchdog clock source and option pins
    input wire wdt_tick_pin,
    input wire opt_response_pin,
    // Device mode, same clock domain
    input wire stop_mode,
    input wire on_chip_debugger_mode,
    // Requests to interrupt controller, reset and stop logic
    output reg wdt_irq_req_q,
    output reg sys_rst_req_q,
    output reg stop_recovery_req_q,
    // Summary interrupt
    output reg irq_q
);

// ============================================================
// Declarations
reg tick_s1_q;
reg tick_s2_q;
reg tick_s3_q;
reg opt_s1_q;
reg opt_s2_q;
reg [1:0] opt_cnt_q;
reg timeout_response_select_q;
reg enable_q;
reg enable_seen_q;
reg [7:0] reload_upper_byte_q;
reg [7:0] reload_middle_byte_q;
reg [7:0] reload_low_byte_q;
reg timeout_flag_q;
reg stop_flag_q;
reg [1:0] int_stat_q;
reg [1:0] int_mask_q;
reg wr_pend_q;
reg [11:0] wr_idx_q;
reg [31:0] rdata_d;
reg [1:0] int_stat_d;
wire addr_acc;
wire rd_acc;
wire wr_now;
wire [11:0] acc_idx;
wire stat_read;
wire tick;
wire refresh_wr;
wire first_enable;
wire cnt_load;
wire expire;
wire timeout_evt;
wire [23:0] count;
wire [23:0] reload_val;

// ============================================================
// Address helpers

function [11:0] word_index;
    input [15:0] addr;
    begin
        word_index = addr[13:2];
    end
endfunction

function is_mapped;
    input [11:0] idx;
    begin
        is_mapped = (idx >= `WDTR_IDX_CTRL) && (idx <= `WDTR_IDX_INT_MASK);
    end
endfunction

// ============================================================
// Pin synchronisers

// The tick pin comes from a separate oscillator, so it passes two
// flops; the edge detector reads only the second and third.
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tick_s1_q <= 1'b0;
        tick_s2_q <= 1'b0;
        tick_s3_q <= 1'b0;
        opt_s1_q <= 1'b0;
        opt_s2_q <= 1'b0;
        enable_seen_q <= 1'b0;
    end
    else
    begin
        tick_s1_q <= wdt_tick_pin;
        tick_s2_q <= tick_s1_q;
        tick_s3_q <= tick_s2_q;
        opt_s1_q <= opt_response_pin;
        opt_s2_q <= opt_s1_q;
        enable_seen_q <= enable_q;
    end
end

assign tick = tick_s2_q && !tick_s3_q;

// ============================================================
// Option bit capture

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        opt_cnt_q <= 2'h0;
        timeout_response_select_q <= 1'b0;
    end
    else if (opt_cnt_q != `WDTR_OPT_CAPTURE)
    begin
        opt_cnt_q <= opt_cnt_q + 2'h1;
        if (opt_cnt_q == (`WDTR_OPT_CAPTURE - 2'h1))
        begin
            timeout_response_select_q <= opt_s2_q;
        end
    end
end

// ============================================================
// AHB-Lite decode

assign addr_acc = hsel && htrans[1] && hready;
assign acc_idx = word_index(haddr);
assign rd_acc = addr_acc && !hwrite;
assign wr_now = wr_pend_q;
assign stat_read = rd_acc && (acc_idx == `WDTR_IDX_STAT);

always @*
begin
    rdata_d = 32'h00000000;
    case (acc_idx)
        `WDTR_IDX_CTRL:
        begin
            rdata_d[`WDTR_CTRL_ENABLE] = enable_q;
        end
        `WDTR_IDX_UPPER:
        begin
            rdata_d[7:0] = count[23:16];
        end
        `WDTR_IDX_MIDDLE:
        begin
            rdata_d[7:0] = count[15:8];
        end
        `WDTR_IDX_LOW:
        begin
            rdata_d[7:0] = count[7:0];
        end
        `WDTR_IDX_STAT:
        begin
            rdata_d[`WDTR_STAT_TIMEOUT] = timeout_flag_q;
            rdata_d[`WDTR_STAT_STOP] = stop_flag_q;
            rdata_d[`WDTR_STAT_RESP] = timeout_response_select_q;
        end
        `WDTR_IDX_INT_STAT:
        begin
            rdata_d[1:0] = int_stat_q;
        end
        `WDTR_IDX_INT_MASK:
        begin
            rdata_d[1:0] = int_mask_q;
        end
        default:
        begin
            rdata_d = 32'h00000000;
        end
    endcase
end

// Zero wait states: read data is sampled in the address phase so that
// it stands for the whole data phase.
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= 32'h00000000;
        wr_pend_q <= 1'b0;
        wr_idx_q <= 12'h000;
    end
    else
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (rd_acc)
        begin
            hrdata <= rdata_d;
        end
        else if (addr_acc)
        begin
            hrdata <= 32'h00000000;
        end
        wr_pend_q <= addr_acc && hwrite && is_mapped(acc_idx);
        if (addr_acc)
        begin
            wr_idx_q <= acc_idx;
        end
    end
end

// ============================================================
// Control and reload registers

assign refresh_wr = wr_now && (wr_idx_q == `WDTR_IDX_CTRL) && hwdata[`WDTR_CTRL_REFRESH];
assign reload_val = {reload_upper_byte_q, reload_middle_byte_q, reload_low_byte_q};

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        enable_q <= 1'b0;
        reload_upper_byte_q <= `WDTR_UPPER_RST;
        reload_middle_byte_q <= `WDTR_MIDDLE_RST;
        reload_low_byte_q <= `WDTR_LOW_RST;
        int_mask_q <= 2'h0;
    end
    else if (wr_now)
    begin
        case (wr_idx_q)
            `WDTR_IDX_CTRL:
            begin
                enable_q <= hwdata[`WDTR_CTRL_ENABLE];
            end
            `WDTR_IDX_UPPER:
            begin
                reload_upper_byte_q <= hwdata[7:0];
            end
            `WDTR_IDX_MIDDLE:
            begin
                reload_middle_byte_q <= hwdata[7:0];
            end
            `WDTR_IDX_LOW:
            begin
                reload_low_byte_q <= hwdata[7:0];
            end
            `WDTR_IDX_INT_MASK:
            begin
                int_mask_q <= hwdata[1:0];
            end
            default:
            begin
                enable_q <= enable_q;
            end
        endcase
    end
end

// ============================================================
// Counter control

assign first_enable = enable_q && !enable_seen_q;
assign cnt_load = first_enable || refresh_wr || on_chip_debugger_mode;

// Counting only runs while enabled; a reload write never loads the
// counter by itself, which keeps the running count undisturbed.
wdtr_counter u_counter
(
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(cnt_load),
    .load_val(reload_val),
    .tick(tick && enable_q),
    .count_q(count),
    .expire(expire)
);

assign timeout_evt = expire;

// ============================================================
// Time-out flags and responses

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        timeout_flag_q <= 1'b0;
        stop_flag_q <= 1'b0;
        wdt_irq_req_q <= 1'b0;
        sys_rst_req_q <= 1'b0;
        stop_recovery_req_q <= 1'b0;
    end
    else
    begin
        wdt_irq_req_q <= timeout_evt && !timeout_response_select_q;
        sys_rst_req_q <= timeout_evt && timeout_response_select_q;
        stop_recovery_req_q <= timeout_evt && !timeout_response_select_q && stop_mode;
        if (timeout_evt)
        begin
            timeout_flag_q <= 1'b1;
            stop_flag_q <= stop_mode || (stop_flag_q && !stat_read);
        end
        else if (stat_read)
        begin
            timeout_flag_q <= 1'b0;
            stop_flag_q <= 1'b0;
        end
    end
end

// ============================================================
// Interrupt status and mask

always @*
begin
    int_stat_d = int_stat_q;
    if (wr_now && (wr_idx_q == `WDTR_IDX_INT_STAT))
    begin
        int_stat_d = int_stat_q & ~hwdata[1:0];
    end
    // A new event beats a write-one-to-clear in the same cycle.
    if (timeout_evt)
    begin
        int_stat_d[`WDTR_STAT_TIMEOUT] = 1'b1;
        if (stop_mode)
        begin
            int_stat_d[`WDTR_STAT_STOP] = 1'b1;
        end
    end
end

always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        int_stat_q <= 2'h0;
        irq_q <= 1'b0;
    end
    else
    begin
        int_stat_q <= int_stat_d;
        irq_q <= |(int_stat_d & int_mask_q);
    end
end

endmodule
